/* File: logic/rfrx_top.sv */
// What this block does
// - carrier is the crystal oscillator rate divided by exactly 128.
// - both drivers toggle at the carrier while transmit_control_n is low.
// - transmit_control_n high: high side driven high, low side released.
// - power_reduce_select low shortens drive duty; high gives full duty.
// - undriven control and power inputs read as high.
// - FSK tones demodulated digitally against oscillator; data and clock out.
// - tone near 134 kHz is bit zero, near 122 kHz is bit one.
// - received bits leave as an NRZ stream in arrival order.
// - receive_data_n low means one, high means zero.
// - receive_clock rises at least 20 us after the data bit starts.
// - data bit stays stable at least 90 us after clock rises.
// - receive_clock stays high at least 55 us each bit period.
`timescale 1ns/1ps
module rfrx_top
  import rfrx_pkg::*;
#(
  parameter int DTVD_CYC_P       = rfrx_pkg::DTVD_CYC,
  parameter int CKHI_CYC_P       = rfrx_pkg::CKHI_CYC,
  parameter int CYCLES_PER_BIT_P = rfrx_pkg::CYCLES_PER_BIT,
  parameter int FIFO_DEPTH_P     = rfrx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // transmitter control pins
  input  wire logic transmit_control_n,
  input  wire logic power_reduce_select,
  // transmitter drivers
  output logic      high_side_drive,
  output logic      low_side_drive,
  output logic      low_side_drive_oe_n,
  // limited receive signal from the amplifier chain
  input  wire logic receive_tone,
  // host link
  output logic      receive_data_n,
  output logic      receive_clock,
  output logic      receive_overrun
);
  import rfrx_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]           txs;
    logic [1:0]           pws;
    logic [1:0]           rxs;
    logic                 rx_d;
    logic [OSC_ACC_W-1:0] acc;
    logic                 osc;
    logic [PHASE_W-1:0]   phase;
    logic                 hi;
    logic                 lo;
    logic                 lo_oe_n;
    logic [PER_W-1:0]     per;
    logic                 run_bit;
    logic [RUN_W-1:0]     run;
    logic                 pend;
    logic                 pend_bit;
    logic                 overrun;
    rfrx_ser_t            st;
    logic [CNT_W-1:0]     cnt;
    logic                 data_n;
    logic                 rck;
  } rfrx_state_t;

  rfrx_state_t s;
  rfrx_state_t next_s;

  // fifo handshake
  logic                 f_in_ready;
  logic                 f_out_valid;
  logic                 f_out_ready;
  logic [FIFO_W-1:0]    f_out_data;

  // ---------------------------------------------------------------
  // bit buffer between demodulator and host link
  // ---------------------------------------------------------------
  rfrx_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (s.pend),
    .in_ready  (f_in_ready),
    .in_data   (s.pend_bit),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // the link only takes a new bit once the previous slot is over
  assign f_out_ready = (s.st == SER_IDLE);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // slot counter step; no slot is long enough to reach the wrap
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
    cnt_step = CNT_W'(c + 1'b1);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [OSC_ACC_W:0] sum;
    logic               tx_on;
    logic               pulse;
    logic [PHASE_W-1:0] duty;
    logic               edge_up;
    logic               cls;
    logic [RUN_W-1:0]   nrun;
    logic               emit;
    next_s  = s;
    sum     = '0;
    tx_on   = 1'b0;
    pulse   = 1'b0;
    edge_up = 1'b0;
    duty   = DUTY_FULL;
    cls    = 1'b0;
    nrun   = '0;
    emit   = 1'b0;

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    next_s.txs  = {s.txs[0], transmit_control_n};
    next_s.pws  = {s.pws[0], power_reduce_select};
    next_s.rxs  = {s.rxs[0], receive_tone};
    next_s.rx_d = s.rxs[1];

    // -------------------------------------------------------------
    // crystal-rate enable
    // -------------------------------------------------------------
    // a phase accumulator keeps the long-term rate exact; single
    // enables jitter by one clk, far below the tone periods
    sum        = {1'b0, s.acc} + {1'b0, OSC_INC};
    next_s.acc = sum[OSC_ACC_W-1:0];
    next_s.osc = sum[OSC_ACC_W];

    // -------------------------------------------------------------
    // transmitter
    // -------------------------------------------------------------
    // divide by 128
    if (s.osc) begin
      next_s.phase = PHASE_W'(s.phase + 1'b1);
    end
    tx_on = ~s.txs[1];
    if (s.pws[1]) begin
      duty = DUTY_FULL;
    end else begin
      duty = DUTY_REDUCED;
    end
    pulse = (s.phase < duty);
    if (tx_on) begin
      next_s.hi      = ~pulse;
      next_s.lo_oe_n = pulse;
    end else begin
      next_s.hi      = 1'b1;
      next_s.lo_oe_n = 1'b1;
    end
    // open drain: only ever pulls low
    next_s.lo = 1'b0;

    // -------------------------------------------------------------
    // demodulator
    // -------------------------------------------------------------
    // rising edge of the limited tone, read past the synchroniser
    edge_up = s.rxs[1] & ~s.rx_d;
    if (s.osc && s.per != PER_MAX) begin
      next_s.per = PER_W'(s.per + 1'b1);
    end
    if (tx_on) begin
      // own carrier swamps the receiver, so no bits are formed
      next_s.per = '0;
      next_s.run = '0;
    end else if (edge_up) begin
      next_s.per = '0;
      if (s.per == PER_MAX || s.per < P_MIN) begin
        // lost tone or glitch: restart bit alignment
        next_s.run = '0;
      end else begin
        // long period is the high-bit tone
        cls = (s.per > P_THRESH);
        if (s.run != '0 && cls == s.run_bit) begin
          nrun = RUN_W'(s.run + 1'b1);
        end else begin
          nrun = RUN_W'(1);
        end
        next_s.run_bit = cls;
        // one bit per run of tone cycles
        if (nrun == RUN_W'(CYCLES_PER_BIT_P)) begin
          emit       = 1'b1;
          next_s.run = '0;
        end else begin
          next_s.run = nrun;
        end
      end
    end

    // -------------------------------------------------------------
    // hand-off into the buffer
    // -------------------------------------------------------------
    // bits kept in arrival order
    if (s.pend && f_in_ready) begin
      next_s.pend = 1'b0;
    end
    if (emit) begin
      if (next_s.pend) begin
        // buffer full and a bit still waiting: newest bit is lost
        next_s.overrun = 1'b1;
      end else begin
        next_s.pend     = 1'b1;
        next_s.pend_bit = cls;
      end
    end

    // -------------------------------------------------------------
    // host link serializer
    // -------------------------------------------------------------
    // a slot is setup plus hold; bits that arrive faster queue up
    case (s.st)
      SER_IDLE: begin
        if (f_out_valid) begin
          next_s.data_n = ~f_out_data[0];
          next_s.rck    = 1'b0;
          next_s.cnt    = '0;
          next_s.st     = SER_SETUP;
        end
      end
      SER_SETUP: begin
        // clock rises 20 us into bit
        if (s.cnt == CNT_W'(DTCK_CYC - 1)) begin
          next_s.rck = 1'b1;
          next_s.cnt = '0;
          next_s.st  = SER_HIGH;
        end else begin
          next_s.cnt = cnt_step(s.cnt);
        end
      end
      SER_HIGH: begin
        if (s.cnt == CNT_W'(CKHI_CYC_P - 1)) begin
          next_s.rck = 1'b0;
          next_s.st  = SER_HOLD;
        end
        next_s.cnt = cnt_step(s.cnt);
      end
      SER_HOLD: begin
        // data held 90 us after rise
        if (s.cnt >= CNT_W'(DTVD_CYC_P - 1)) begin
          next_s.st = SER_IDLE;
        end else begin
          next_s.cnt = cnt_step(s.cnt);
        end
      end
      default: begin
        next_s.st = SER_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s         <= '0;
      // inputs default to receive, full power
      s.txs     <= SYNC_RST;
      s.pws     <= SYNC_RST;
      s.hi      <= 1'b1;
      s.lo_oe_n <= 1'b1;
      s.data_n  <= DATA_N_RST;
      s.st      <= SER_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign high_side_drive     = s.hi;
  assign low_side_drive      = s.lo;
  assign low_side_drive_oe_n = s.lo_oe_n;
  assign receive_data_n      = s.data_n;
  assign receive_clock       = s.rck;
  assign receive_overrun     = s.overrun;

endmodule // rfrx_top

/* File: logic/rfrx_pkg.sv */
package rfrx_pkg;

  // ---------------------------------------------------------------
  // clocks and rates
  // ---------------------------------------------------------------
  localparam int CLK_HZ   = 200_000_000;
  localparam int OSC_HZ   = 17_177_600;
  localparam int OSC_ACC_W = 24;
  // phase step of the crystal-rate enable, fraction of one clk
  localparam logic [OSC_ACC_W-1:0] OSC_INC =
    OSC_ACC_W'((longint'(OSC_HZ) << OSC_ACC_W) / longint'(CLK_HZ));

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  localparam int             CARRIER_DIV  = 128;
  localparam int             PHASE_W      = $clog2(CARRIER_DIV);
  localparam logic [PHASE_W-1:0] DUTY_FULL    = 7'h40;
  localparam logic [PHASE_W-1:0] DUTY_REDUCED = 7'h20;

  // ---------------------------------------------------------------
  // demodulator
  // ---------------------------------------------------------------
  localparam int F_LOW_HZ  = 134_200;
  localparam int F_HIGH_HZ = 122_000;
  localparam int PER_W     = 8;
  localparam logic [PER_W-1:0] PER_MAX  = 8'hFF;
  localparam logic [PER_W-1:0] P_LOW    = PER_W'(OSC_HZ / F_LOW_HZ);
  localparam logic [PER_W-1:0] P_HIGH   = PER_W'(OSC_HZ / F_HIGH_HZ);
  localparam logic [PER_W-1:0] P_THRESH =
    PER_W'((OSC_HZ / F_LOW_HZ + OSC_HZ / F_HIGH_HZ) / 2);
  localparam logic [PER_W-1:0] P_MIN    = PER_W'(OSC_HZ / F_LOW_HZ / 2);
  localparam int RUN_W          = 8;
  localparam int CYCLES_PER_BIT = 16;

  // ---------------------------------------------------------------
  // receive clock and data timing
  // ---------------------------------------------------------------
  localparam int T_DTCK_US = 20;
  localparam int T_DTVD_US = 90;
  localparam int T_CKHI_US = 55;
  localparam int CNT_W     = 20;

  // least time in microseconds to whole clk cycles, rounded up
  function automatic int us_to_cyc(input int us);
    us_to_cyc = int'((longint'(us) * CLK_HZ + 999_999) / 1_000_000);
  endfunction

  localparam int DTCK_CYC = us_to_cyc(T_DTCK_US);
  localparam int DTVD_CYC = us_to_cyc(T_DTVD_US);
  localparam int CKHI_CYC = us_to_cyc(T_CKHI_US);

  // ---------------------------------------------------------------
  // buffering and reset values
  // ---------------------------------------------------------------
  localparam int FIFO_W     = 1;
  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] SYNC_RST   = 2'b11;
  localparam logic       DATA_N_RST = 1'b1;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_SETUP = 2'b01,
    SER_HIGH  = 2'b10,
    SER_HOLD  = 2'b11
  } rfrx_ser_t;

endpackage

/* File: logic/rfrx_fifo.sv */
`timescale 1ns/1ps
module rfrx_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import rfrx_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } rfrx_fifo_t;

  rfrx_fifo_t s;
  rfrx_fifo_t next_s;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic pop;
    logic load;
    logic push;
    next_s = s;
    pop    = s.ov & out_ready;
    // read data leaves through a register so the drain sees no mux
    load   = (~s.ov | pop) & (s.cnt != '0);
    push   = in_valid & (s.cnt != (AW+1)'(DEPTH));
    if (pop) begin
      next_s.ov = 1'b0;
    end
    if (load) begin
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = bump(s.rp);
    end
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = bump(s.wp);
    end
    if (push && !load) begin
      next_s.cnt = (AW+1)'(s.cnt + 1'b1);
    end else if (load && !push) begin
      next_s.cnt = (AW+1)'(s.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = s.ov;
  assign out_data  = s.od;

endmodule // rfrx_fifo

/* File: bench/rfrx_monitor.sv */
`timescale 1ns/1ps
module rfrx_monitor
  import rfrx_pkg::*;
#(
  parameter int DTVD_CYC_P = 18000,
  parameter int CKHI_CYC_P = 11000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // transmitter
  input wire logic transmit_control_n,
  input wire logic power_reduce_select,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic low_side_drive_oe_n,
  // receiver
  input wire logic receive_tone,
  input wire logic receive_data_n,
  input wire logic receive_clock,
  input wire logic receive_overrun
);
  import rfrx_pkg::*;
  // ---------------------------------------------------------------
  // run-length counters; ck_lo and since_rise saturate so long idles stay legal
  // ---------------------------------------------------------------
  localparam int PULSE_MAX =
    int'((longint'(DUTY_FULL) * CLK_HZ) / OSC_HZ) + 2;
  logic [15:0] lo_run;
  logic [15:0] ck_hi;
  logic [15:0] ck_lo;
  logic [15:0] since_rise;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lo_run     <= '0;
      ck_hi      <= '0;
      ck_lo      <= '0;
      since_rise <= 16'hFFFF;
    end else begin
      lo_run <= high_side_drive ? 16'h0 : lo_run + 16'h1;
      ck_hi  <= receive_clock ? ck_hi + 16'h1 : 16'h0;
      if (receive_clock) begin
        ck_lo <= '0;
      end else if (ck_lo != 16'hFFFF) begin
        ck_lo <= ck_lo + 16'h1;
      end
      if (receive_clock && ck_hi == 16'h0) begin
        since_rise <= 16'h1;
      end else if (since_rise != 16'hFFFF) begin
        since_rise <= since_rise + 16'h1;
      end
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rx_mode;
    transmit_control_n [*5] |-> high_side_drive && low_side_drive_oe_n;
  endproperty
  property p_lo_zero;
    !low_side_drive;
  endproperty
  property p_tx_comp;
    !transmit_control_n [*5] |-> low_side_drive_oe_n == !high_side_drive;
  endproperty
  property p_pulse_max;
    lo_run <= PULSE_MAX;
  endproperty
  property p_ck_high;
    $fell(receive_clock) |-> ck_hi >= CKHI_CYC_P;
  endproperty
  property p_data_hold;
    $changed(receive_data_n) |-> since_rise >= DTVD_CYC_P;
  endproperty
  property p_setup;
    $rose(receive_clock) |-> ck_lo >= DTCK_CYC;
  endproperty
  property p_clk_low;
    $fell(receive_clock) |=> !receive_clock [*8];
  endproperty
  property p_overrun;
    receive_overrun |=> receive_overrun;
  endproperty
  a_rx_mode: assert property (p_rx_mode)
    else $error("drivers not idle in receive mode");
  a_lo_zero: assert property (p_lo_zero)
    else $error("low side value not zero");
  a_tx_comp: assert property (p_tx_comp)
    else $error("drivers not complementary");
  a_pulse_max: assert property (p_pulse_max)
    else $error("drive pulse longer than full duty");
  a_ck_high: assert property (p_ck_high)
    else $error("receive clock high too short");
  a_data_hold: assert property (p_data_hold)
    else $error("data changed too soon after clock rise");
  a_setup: assert property (p_setup)
    else $error("clock rose too soon after bit start");
  a_clk_low: assert property (p_clk_low)
    else $error("receive clock low too short");
  a_overrun: assert property (p_overrun)
    else $error("overrun flag dropped");
  c_bit: cover property ($rose(receive_clock));
  c_ovr: cover property ($rose(receive_overrun));
  c_tx: cover property (!transmit_control_n && $fell(high_side_drive));
endmodule // rfrx_monitor

/* File: bench/rfrx_host_model.sv */
`timescale 1ns/1ps
module rfrx_host_model (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rstn,
  // serial link from the reader
  input  wire logic   receive_data_n,
  input  wire logic   receive_clock,
  // decoded bits, newest in bit 0
  output int          n_bits,
  output logic [63:0] bits
);
  logic ck_prev;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ck_prev <= 1'b0;
      n_bits  <= 0;
      bits    <= '0;
    end else begin
      ck_prev <= receive_clock;
      if (receive_clock && !ck_prev) begin
        bits   <= {bits[62:0], ~receive_data_n};
        n_bits <= n_bits + 1;
      end
    end
  end
endmodule // rfrx_host_model

/* File: bench/rfrx_top_tb.sv */
`timescale 1ns/1ps
module rfrx_top_tb;
  import rfrx_pkg::*;
  // ---------------------------------------------------------------
  // pins; control pins carry the pull-ups of the real pads
  // ---------------------------------------------------------------
  logic        clk;
  logic        rstn;
  logic        txc_drv;
  logic        txc_en;
  logic        pwr_drv;
  logic        pwr_en;
  logic        receive_tone;
  tri1         transmit_control_n;
  tri1         power_reduce_select;
  logic        high_side_drive;
  logic        low_side_drive;
  logic        low_side_drive_oe_n;
  logic        receive_data_n;
  logic        receive_clock;
  logic        receive_overrun;
  int          n_bits;
  logic [63:0] bits;
  int          cyc_n;
  int          num_errors;
  int          n_compared;
  assign transmit_control_n  = txc_en ? txc_drv : 1'bz;
  assign power_reduce_select = pwr_en ? pwr_drv : 1'bz;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  // short hold times keep the run brief; small fifo reaches overrun
  rfrx_top #(.DTVD_CYC_P(40), .CKHI_CYC_P(25), .CYCLES_PER_BIT_P(1),
    .FIFO_DEPTH_P(4)) u_rfrx_top (.clk(clk), .rstn(rstn),
    .transmit_control_n(transmit_control_n),
    .power_reduce_select(power_reduce_select),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .low_side_drive_oe_n(low_side_drive_oe_n),
    .receive_tone(receive_tone), .receive_data_n(receive_data_n),
    .receive_clock(receive_clock), .receive_overrun(receive_overrun));
  rfrx_host_model u_rfrx_host_model (.clk(clk), .rstn(rstn),
    .receive_data_n(receive_data_n), .receive_clock(receive_clock),
    .n_bits(n_bits), .bits(bits));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input int tol);
    n_compared++;
    if ((tol == 0) ? (got !== exp) :
        ($isunknown(got) || got > exp + tol || got + tol < exp)) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic int t2c(input int ticks);
    return int'((longint'(ticks) * CLK_HZ) / OSC_HZ);
  endfunction
  task automatic wait_hi(input logic lvl);
    int k;
    for (k = 0; k < 4000 && high_side_drive !== lvl; k++) begin
      @(negedge clk);
    end
    if (k >= 4000) begin
      num_errors++;
      end_sim();
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rstn = 1'b0;
    cyc(5);
    rstn = 1'b1;
    cyc(3);
    check(high_side_drive, 1, 0);
    check(low_side_drive_oe_n, 1, 0);
    check({receive_data_n, receive_clock, receive_overrun}, 3'h4, 0);
  endtask
  // mode 0 power pin open, 1 driven high, 2 driven low
  task automatic t_tx(input int mode);
    int t0;
    int t1;
    pwr_en  = (mode != 0);
    pwr_drv = (mode == 1);
    txc_en  = 1'b1;
    txc_drv = 1'b0;
    wait_hi(1'b0);
    wait_hi(1'b1);
    wait_hi(1'b0);
    t0 = cyc_n;
    check(low_side_drive_oe_n, 1, 0);
    wait_hi(1'b1);
    t1 = cyc_n;
    check(low_side_drive_oe_n, 0, 0);
    check(t1 - t0, t2c(mode == 2 ? DUTY_REDUCED : DUTY_FULL), 2);
    wait_hi(1'b0);
    check(cyc_n - t0, t2c(CARRIER_DIV), 2);
    txc_en = 1'b0;
    cyc(6);
    check({high_side_drive, low_side_drive_oe_n}, 2'h3, 0);
  endtask
  // one idle-to-tone edge first, then one tone cycle per bit
  task automatic send(input logic [15:0] pat, input int n);
    int p;
    receive_tone = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      p = t2c(pat[i] ? P_HIGH : P_LOW);
      cyc(p / 2);
      receive_tone = 1'b0;
      cyc(p - p / 2);
      receive_tone = 1'b1;
    end
    cyc(700);
    receive_tone = 1'b0;
  endtask
  task automatic wait_quiet;
    int q;
    int k;
    q = 0;
    for (k = 0; k < 40000 && q < 4200; k++) begin
      @(negedge clk);
      q = receive_clock ? 0 : q + 1;
    end
    if (q < 4200) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic t_rx;
    int n0;
    n0 = n_bits;
    send(16'h0016, 5);
    wait_quiet();
    check(n_bits - n0, 5, 0);
    check(bits[4:0], 5'h16, 0);
    check(receive_overrun, 0, 0);
  endtask
  task automatic t_ovr;
    int n0;
    logic [63:0] m;
    n0 = n_bits;
    send(16'h0FFF, 12);
    wait_quiet();
    m = (64'h1 << (n_bits - n0)) - 64'h1;
    check(receive_overrun, 1, 0);
    check(n_bits - n0 < 12, 1, 0);
    check((bits & m) == m, 1, 0);
  endtask
  initial begin
    clk          = 1'b0;
    rstn         = 1'b0;
    txc_drv      = 1'b1;
    txc_en       = 1'b0;
    pwr_drv      = 1'b1;
    pwr_en       = 1'b0;
    receive_tone = 1'b0;
    cyc_n        = 0;
    num_errors   = 0;
    n_compared   = 0;
    t_reset();
    for (int m = 0; m < 3; m++) begin
      t_tx(m);
    end
    t_rx();
    t_ovr();
    t_reset();
    end_sim();
  end
endmodule // rfrx_top_tb

bind rfrx_top rfrx_monitor #(.DTVD_CYC_P(DTVD_CYC_P),
  .CKHI_CYC_P(CKHI_CYC_P)) u_rfrx_monitor (.clk(clk), .rstn(rstn),
  .transmit_control_n(transmit_control_n),
  .power_reduce_select(power_reduce_select),
  .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
  .low_side_drive_oe_n(low_side_drive_oe_n),
  .receive_tone(receive_tone), .receive_data_n(receive_data_n),
  .receive_clock(receive_clock), .receive_overrun(receive_overrun));
